// ==== regcfg_consts.svh ====
// constants for the regulator configuration register bank
`ifndef REGCFG_CONSTS_SVH
`define REGCFG_CONSTS_SVH
`define PAGE_VOLT          2'h1
`define PAGE_GENERAL       2'h2
`define OFS_VOLT_CTRL      8'h10
`define OFS_VOLT_CTRL_INV  8'h11
`define OFS_PROT_KEY       8'h03
`define OFS_STATE_REQ      8'h00
`define PAGE_STATE         2'h0
`define RST_VOLT_CTRL      4'h2
`define RST_VOLT_CTRL_INV  4'hD
`define RST_PROT_KEY       8'h00
`define RST_STATE_REQ      3'h0
`define STATE_CODE_LOCKED  3'h0
`define STATE_CODE_ACTIVE  3'h6
`define STATE_CODE_DISABLED 3'h4
`define MAX_FINE_CODE      4'h8
`define FINE_CODE_ALL_ONES 4'hF
`define RST_RDATA          8'h00
`define RDATA_UNMAPPED     8'h00
`endif

// ==== regcfg_pkg.sv ====
// types for the regulator configuration register bank
package regcfg_pkg;
   typedef enum logic [1:0] {
      st_locked,
      st_disabled,
      st_active,
      st_reserved
   } dev_state_t;
endpackage : regcfg_pkg

// ==== regulator_config_registers.sv ====
// regulator configuration register bank behind the spi register port
`timescale 1ns/1ps
`include "regcfg_consts.svh"

// Functional notes
// - state request code 06 hex means request active state
// - fine code bits 3:0 select 1.30..0.90 V; bits 7:4 read zero
// - voltage control at page 1 offset 10 hex, resets to 02 hex
// - inverted shadow holds complement of fine code, resets to 0D hex
// - protection key at page 2 offset 03 hex, 8-bit rw, resets 00
module regulator_config_registers (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rstn,
   // register access from the spi frame decoder
   input  wire logic                    reg_wr,
   input  wire logic [1:0]              reg_page,
   input  wire logic [7:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   output logic      [7:0]              reg_rdata,
   // decoded device state request
   output regcfg_pkg::dev_state_t       device_state_request,
   // applied regulator setting
   output logic      [3:0]              fine_voltage_code,
   output logic                         shadow_mismatch,
   // protection key to the lock logic
   output logic      [7:0]              config_protection_key
);

   // timing at a glance:
   // a write lands at the edge that sees reg_wr high and shows the cycle after;
   // read data lags the address by one cycle, since it comes from a flip-flop;
   // the applied code follows one edge after the voltage pair agrees;
   // the decoded state follows one edge after the request code is stored.

   // register storage
   logic [2:0]              state_req_ff;    // request code as last written
   logic [3:0]              volt_ff;         // fine code as last written
   logic [3:0]              volt_inv_ff;     // inverted shadow as last written
   logic [3:0]              applied_ff;      // code the regulator actually uses
   logic [7:0]              key_ff;          // protection key
   logic [7:0]              rdata_ff;        // read data for the previous address
   regcfg_pkg::dev_state_t  state_ff;        // decoded device state

   // next values
   logic [2:0]              nxt_state_req;
   logic [3:0]              nxt_volt;
   logic [3:0]              nxt_volt_inv;
   logic [3:0]              nxt_applied;
   logic [7:0]              nxt_key;
   logic [7:0]              nxt_rdata;
   regcfg_pkg::dev_state_t  nxt_state;

   // register selects and write enables
   logic                    hit_state;
   logic                    hit_volt;
   logic                    hit_vinv;
   logic                    hit_key;
   logic                    wr_state;
   logic                    wr_volt;
   logic                    wr_vinv;
   logic                    wr_key;

   // voltage pair checks
   logic                    pair_compl;
   logic                    code_mapped;
   logic                    pair_ok;

   // state request decode
   regcfg_pkg::dev_state_t  req_state;
   logic                    req_known;

   // one page and offset compare, shared by every register select
   function automatic logic reg_hit(
      input logic [1:0] page,
      input logic [7:0] ofs,
      input logic [1:0] want_page,
      input logic [7:0] want_ofs
   );
      reg_hit = (page == want_page) && (ofs == want_ofs);
   endfunction : reg_hit

   // widen a four-bit field to the read bus; the unused upper nibble reads zero
   function automatic logic [7:0] pad_nibble(
      input logic [3:0] nib
   );
      pad_nibble = {4'h0, nib};
   endfunction : pad_nibble

   // address decode; page and offset must both match, so other pages stay dark
   assign hit_state = reg_hit(reg_page, reg_addr, `PAGE_STATE, `OFS_STATE_REQ);
   assign hit_volt  = reg_hit(reg_page, reg_addr, `PAGE_VOLT, `OFS_VOLT_CTRL);
   assign hit_vinv  = reg_hit(reg_page, reg_addr, `PAGE_VOLT, `OFS_VOLT_CTRL_INV);
   assign hit_key   = reg_hit(reg_page, reg_addr, `PAGE_GENERAL, `OFS_PROT_KEY);

   // write enables; a write to an unmapped offset selects nothing and is dropped
   assign wr_state  = reg_wr && hit_state;
   assign wr_volt   = reg_wr && hit_volt;
   assign wr_vinv   = reg_wr && hit_vinv;
   assign wr_key    = reg_wr && hit_key;

   // next register values; only the low nibble of the voltage pair is stored
   assign nxt_state_req = wr_state ? reg_wdata[2:0] : state_req_ff;
   assign nxt_volt      = wr_volt  ? reg_wdata[3:0] : volt_ff;
   assign nxt_volt_inv  = wr_vinv  ? reg_wdata[3:0] : volt_inv_ff;
   assign nxt_key       = wr_key   ? reg_wdata      : key_ff;

   // pair agrees only when the shadow is the exact complement and the code is mapped;
   // codes 9..F with a matching shadow still count as disagreeing, so an unmapped
   // code can never reach the regulator even if software writes it consistently
   assign pair_compl  = ((volt_ff ^ volt_inv_ff) == `FINE_CODE_ALL_ONES);
   assign code_mapped = (volt_ff <= `MAX_FINE_CODE);
   assign pair_ok     = pair_compl && code_mapped;

   // applied code holds the last agreeing pair, so a half-done update is harmless
   assign nxt_applied = pair_ok ? volt_ff : applied_ff;

   // code decode; only the listed codes name a state
   always_comb begin
      unique case (state_req_ff)
         `STATE_CODE_LOCKED:   req_state = regcfg_pkg::st_locked;
         `STATE_CODE_ACTIVE:   req_state = regcfg_pkg::st_active;
         `STATE_CODE_DISABLED: req_state = regcfg_pkg::st_disabled;
         default:              req_state = regcfg_pkg::st_reserved;
      endcase
   end

   // reserved codes leave the state where it was rather than guessing
   assign req_known = (req_state != regcfg_pkg::st_reserved);
   assign nxt_state = req_known ? req_state : state_ff;

   // readback select; unmapped offsets read zero
   assign nxt_rdata = hit_state ? {5'h00, state_req_ff}
                    : hit_volt  ? pad_nibble(volt_ff)
                    : hit_vinv  ? pad_nibble(volt_inv_ff)
                    : hit_key   ? key_ff
                    : `RDATA_UNMAPPED;

   // raw state request code; reset leaves the device locked
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_req_ff <= `RST_STATE_REQ;
      end else begin
         state_req_ff <= nxt_state_req;
      end
   end

   // fine voltage code as written; reset selects the nominal output
   always_ff @(posedge clk) begin
      if (!rstn) begin
         volt_ff <= `RST_VOLT_CTRL;
      end else begin
         volt_ff <= nxt_volt;
      end
   end

   // inverted shadow as written; reset value agrees with the code reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         volt_inv_ff <= `RST_VOLT_CTRL_INV;
      end else begin
         volt_inv_ff <= nxt_volt_inv;
      end
   end

   // protection key; plain storage, the lock logic judges its value
   always_ff @(posedge clk) begin
      if (!rstn) begin
         key_ff <= `RST_PROT_KEY;
      end else begin
         key_ff <= nxt_key;
      end
   end

   // applied code; costs one cycle of latency after the pair agrees,
   // but keeps a single written half of the pair away from the regulator
   always_ff @(posedge clk) begin
      if (!rstn) begin
         applied_ff <= `RST_VOLT_CTRL;
      end else begin
         applied_ff <= nxt_applied;
      end
   end

   // decoded device state; registered so the state output never glitches
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_ff <= regcfg_pkg::st_locked;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // read data register; one cycle behind the address
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_ff <= `RST_RDATA;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // outputs; all from flip-flops except the mismatch level, a status
   // that software may poll while it rewrites the pair
   assign reg_rdata             = rdata_ff;
   assign device_state_request  = state_ff;
   assign fine_voltage_code     = applied_ff;
   assign shadow_mismatch       = !pair_ok;
   assign config_protection_key = key_ff;

endmodule : regulator_config_registers

// ==== regcfg_properties.sv ====
// assertions on the register bank ports
`timescale 1ns/1ps
module regcfg_properties (input wire logic clk, rstn, reg_wr, shadow_mismatch,
   input wire logic [1:0] reg_page, input wire logic [3:0] fine_voltage_code,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, config_protection_key,
   input wire regcfg_pkg::dev_state_t device_state_request);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // short aliases and decoded strobes, kept as nets so no sampled call sits outside a property
   wire [7:0] k = config_protection_key;
   wire [3:0] f = fine_voltage_code;
   wire kr = reg_page == 2'h2 && reg_addr == 8'h03;
   wire kw = reg_wr && kr;
   wire sw = reg_wr && reg_page == 2'h0 && reg_addr == 8'h00;
   a_key_set: assert property (kw |=> k == $past(reg_wdata)) else $error("key write lost");
   a_key_hold: assert property (!kw |=> $stable(k)) else $error("key changed");
   a_key_read: assert property (kr && !reg_wr |=> reg_rdata == k) else $error("key read");
   a_go_active: assert property (sw && reg_wdata[2:0] == 3'h6 |=> ##1
      device_state_request == regcfg_pkg::st_active) else $error("state not active");
   a_go_locked: assert property (sw && reg_wdata[2:0] == 3'h0 |=> ##1
      device_state_request == regcfg_pkg::st_locked) else $error("state not locked");
   a_top_zero: assert property (reg_page == 2'h1 |=> reg_rdata[7:4] == 4'h0) else $error("bits");
   a_apply_pair: assert property ($changed(f) |-> !$past(shadow_mismatch) && f <= 4'h8)
      else $error("code applied without agreeing pair");
   a_reset_vals: assert property ($rose(rstn) |-> f == 4'h2 && k == 8'h00 && !shadow_mismatch)
      else $error("reset value");
   c_active: cover property (device_state_request == regcfg_pkg::st_active);
   c_apply: cover property ($changed(f));
   c_mismatch: cover property (shadow_mismatch);
endmodule : regcfg_properties
bind regulator_config_registers regcfg_properties i_regcfg_properties (.*);

// ==== mcu_master.sv ====
// microcontroller model driving register accesses
`timescale 1ns/1ps
module mcu_master (
   // clock
   input  wire logic       clk,
   // register access strobe and payload
   output logic            reg_wr    = 1'b0,
   output logic [1:0]      reg_page  = 2'h0,
   output logic [7:0]      reg_addr  = 8'h00,
   output logic [7:0]      reg_wdata = 8'h00
);
   // strobe for one cycle; address stays put so the registered read data remains valid
   task automatic acc(input logic w, input logic [1:0] p, input logic [7:0] ad, d);
      @(posedge clk);
      #1 {reg_wr, reg_page, reg_addr, reg_wdata} = {w, p, ad, d};
      @(posedge clk);
      #1 reg_wr = 1'b0;
   endtask : acc
endmodule : mcu_master

// ==== regulator_config_registers_bench.sv ====
// self-checking bench for the regulator configuration registers
`timescale 1ns/1ps
module regulator_config_registers_bench;
   logic clk = 1'b0, rstn = 1'b0, reg_wr, shadow_mismatch;
   logic [1:0] reg_page;
   logic [3:0] fine_voltage_code;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, config_protection_key;
   regcfg_pkg::dev_state_t device_state_request;
   int n_mismatch = 0, n_compared = 0;
   // clock, design and microcontroller model
   always #50 clk = ~clk;
   regulator_config_registers i_regulator_config_registers (.*);
   mcu_master i_mcu_master (.*);
   // count every compare, report a mismatch at once
   task automatic chk(input logic [7:0] seen, exp);
      n_compared++;
      n_mismatch += int'(seen !== exp);
      if (seen !== exp) $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
   endtask : chk
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   // reset shadow, top code with high bits set, then a lone code that must not apply
   task automatic t_volt();
      i_mcu_master.acc(0, 2'h1, 8'h10, 8'h00);
      chk(reg_rdata, 8'h02);
      i_mcu_master.acc(0, 2'h1, 8'h11, 8'h00);
      chk(reg_rdata, 8'h0D);
      i_mcu_master.acc(1, 2'h1, 8'h10, 8'hF8);
      i_mcu_master.acc(1, 2'h1, 8'h11, 8'h07);
      i_mcu_master.acc(0, 2'h1, 8'h10, 8'h00);
      chk(reg_rdata, 8'h08);
      i_mcu_master.acc(1, 2'h1, 8'h10, 8'h05);
      chk({3'h0, shadow_mismatch, fine_voltage_code}, 8'h18);
      i_mcu_master.acc(1, 2'h1, 8'h11, 8'h0A);
      i_mcu_master.acc(1, 2'h1, 8'h10, 8'h09);
      i_mcu_master.acc(1, 2'h1, 8'h11, 8'h06);
      chk({3'h0, shadow_mismatch, fine_voltage_code}, 8'h15);
      $display("t_volt done");
   endtask : t_volt
   // active, reserved code ignored, locked again; then the key
   task automatic t_state();
      i_mcu_master.acc(1, 2'h0, 8'h00, 8'h06);
      i_mcu_master.acc(1, 2'h0, 8'h00, 8'h01);
      i_mcu_master.acc(1, 2'h0, 8'h00, 8'h00);
      chk(8'(device_state_request), 8'(regcfg_pkg::st_active));
      i_mcu_master.acc(0, 2'h2, 8'h03, 8'h00);
      chk(8'(device_state_request), 8'(regcfg_pkg::st_locked));
      chk(reg_rdata, 8'h00);
      i_mcu_master.acc(1, 2'h2, 8'h03, 8'hA5);
      i_mcu_master.acc(0, 2'h2, 8'h03, 8'h00);
      chk(reg_rdata, 8'hA5);
      chk(config_protection_key, 8'hA5);
      i_mcu_master.acc(1, 2'h0, 8'h00, 8'h04);
      i_mcu_master.acc(0, 2'h0, 8'h00, 8'h00);
      chk(reg_rdata, 8'h04);
      chk(8'(device_state_request), 8'(regcfg_pkg::st_disabled));
      $display("t_state done");
   endtask : t_state
   // three cycles of reset, then the tests
   initial begin
      repeat (3) @(posedge clk);
      #1 rstn = 1'b1;
      t_volt();
      t_state();
      tally_and_finish();
   end
   // the tests need a few microseconds; this cuts a hang short
   initial begin
      #50us;
      n_mismatch++;
      tally_and_finish();
   end
endmodule : regulator_config_registers_bench
